// File: i2c_ack_defs.svh
`ifndef I2C_ACK_DEFS_SVH
`define I2C_ACK_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADR_CTRL     8'hc0
`define ADR_OWN      8'hc1
`define ADR_STATUS   8'hd0
`define ADR_TXDATA   8'hd1
`define ADR_RXDATA   8'hd2
`define ADR_IRQ_STS  8'hd3
`define ADR_IRQ_CLR  8'hd4
`define ADR_IRQ_EN   8'hd5

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CTRL_EN      6
`define CTRL_SI      3
`define CTRL_ACK     2
`define CTRL_PX      0
`define OWN_CALL     0
`define OWN_RESET    8'h00
`define STATUS_RESET 8'hf8
`define PIN_RESET    4'hf

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define IRQ_SI       0
`define IRQ_HIT      1
`define IRQ_DROP     2
`define IRQ_W        3

// ----------------------------------------
// status codes
// ----------------------------------------
`define ST_OWN_W     8'h60
`define ST_CALL_W    8'h70
`define ST_RX_ACK    8'h80
`define ST_RX_NACK   8'h88
`define ST_CALL_ACK  8'h90
`define ST_CALL_NACK 8'h98
`define ST_STOP      8'ha0
`define ST_OWN_R     8'ha8
`define ST_TX_ACK    8'hb8
`define ST_TX_NACK   8'hc0
`define ST_TX_LAST   8'hc8

// ----------------------------------------
// byte framing
// ----------------------------------------
`define BITS_BYTE    4'h8
`define LAST_TX_FALL 4'h7
`define CALL_ADDR    7'h00

`endif

// File: i2c_ack_pkg.sv
package i2c_ack_pkg;

	// slave sequencer states
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ADDR    = 3'b001,
		ST_ACK_A   = 3'b010,
		ST_RX      = 3'b011,
		ST_RX_ACK  = 3'b100,
		ST_TX_LOAD = 3'b101,
		ST_TX      = 3'b110,
		ST_TX_ACK  = 3'b111
	} seq_state_t;

	// one scl/sda pair as seen after the synchroniser
	typedef struct packed {
		logic sda;
		logic scl;
	} pin_pair_t;

	// software control bits
	typedef struct packed {
		logic en;
		logic ack;
		logic px;
	} ctrl_t;

endpackage

// File: pin_sync.sv
`timescale 1ns/10ps
`include "i2c_ack_defs.svh"

module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// three stages; a bit moves once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= WIDTH'(`PIN_RESET);
			s2_q <= WIDTH'(`PIN_RESET);
			s3_q <= WIDTH'(`PIN_RESET);
			q    <= WIDTH'(`PIN_RESET);
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q    <= (q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
		end
	end

endmodule

// File: i2c_slave_addressing_ack.sv
`timescale 1ns/10ps
`include "i2c_ack_defs.svh"

// What this block does
// RQ1: ack enabled: pull SDA low on ack
// RQ2: ack disabled: leave SDA high on ack
// RQ3: ack disabled: ignore addresses, no interrupt
// RQ4: missing ack drops slave to not-addressed
// RQ5: ack cleared before last byte: C8, drop
// RQ6: select bit picks one of two pin pairs
// RQ7: pin pairs switch at once on write
// RQ8: match 7-bit own address after start
// RQ9: match plus ack enabled: ack, become addressed
// RQ10: own address, call enable unused as master
// RQ11: general call needs its enable and ack
// RQ12: software sets nonzero own address first
// RQ13: master sends our address after start
// RQ14: flag on each status, stretch SCL meanwhile unless now idle
// RQ15: bus works only while interface enabled
// RQ16: address bit zero picks read or write
module i2c_slave_addressing_ack (
	input  wire logic       SYS_CLK,
	input  wire logic       RESETN,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WR_DATA,
	input  wire logic       WR_STB,
	input  wire logic       RD_STB,
	output logic      [7:0] RD_DATA,
	output logic            IRQ,
	input  wire logic       SCL_A_IN,
	output logic            SCL_A_OUT,
	output logic            SCL_A_OE,
	input  wire logic       SDA_A_IN,
	output logic            SDA_A_OUT,
	output logic            SDA_A_OE,
	input  wire logic       SCL_B_IN,
	output logic            SCL_B_OUT,
	output logic            SCL_B_OE,
	input  wire logic       SDA_B_IN,
	output logic            SDA_B_OUT,
	output logic            SDA_B_OE
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	i2c_ack_pkg::ctrl_t      ctrl_q;
	i2c_ack_pkg::seq_state_t state_q;
	i2c_ack_pkg::pin_pair_t  pair_a;
	i2c_ack_pkg::pin_pair_t  pair_b;
	i2c_ack_pkg::pin_pair_t  pair_s;
	logic [3:0]              pins_s;
	logic                    si_q;
	logic [7:0]              own_q;
	logic [7:0]              tx_data_q;
	logic [7:0]              rx_data_q;
	logic [7:0]              status_q;
	logic [`IRQ_W-1:0]       irq_sts_q;
	logic [`IRQ_W-1:0]       irq_en_q;
	logic [7:0]              rd_q;
	logic                    irq_q;
	logic                    scl_prev_q;
	logic                    sda_prev_q;
	logic [3:0]              cnt_q;
	logic [7:0]              sh_q;
	logic                    sda_drv_q;
	logic                    scl_drv_q;
	logic                    addressed_q;
	logic                    call_q;
	logic                    rw_q;
	logic                    acked_q;
	logic                    last_q;
	logic                    ev_q;
	logic                    hit_ev_q;
	logic                    drop_ev_q;
	logic                    scl_a_oe_q;
	logic                    sda_a_oe_q;
	logic                    scl_b_oe_q;
	logic                    sda_b_oe_q;
	logic                    scl_rise;
	logic                    scl_fall;
	logic                    start_c;
	logic                    stop_c;
	logic                    wr_ctrl;
	logic                    hit_own;
	logic                    hit_call;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// address byte decode: own match or enabled general call
	function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] own, input logic call_ok);
		addr_hit = (a == `CALL_ADDR) ? call_ok : (a == own);
	endfunction

	// ----------------------------------------
	// pin sampling and routing
	// ----------------------------------------
	pin_sync #(
		.WIDTH (4)
	) u_sync (
		.clk   (SYS_CLK),
		.rst_n (RESETN),
		.d     ({SDA_B_IN, SCL_B_IN, SDA_A_IN, SCL_A_IN}),
		.q     (pins_s)
	);

	// selected pair follows the select bit directly
	assign pair_a = {pins_s[1], pins_s[0]};
	assign pair_b = {pins_s[3], pins_s[2]};
	assign pair_s = ctrl_q.px ? pair_b : pair_a; // RQ6 RQ7

	// bus conditions on the selected pair
	assign scl_rise = pair_s.scl & ~scl_prev_q;
	assign scl_fall = ~pair_s.scl & scl_prev_q;
	assign start_c  = pair_s.scl & scl_prev_q & sda_prev_q & ~pair_s.sda;
	assign stop_c   = pair_s.scl & scl_prev_q & ~sda_prev_q & pair_s.sda;

	// address decode, gated by ack enable
	assign hit_call = (sh_q[7:1] == `CALL_ADDR) && own_q[`OWN_CALL] && ctrl_q.ack && !sh_q[0]; // RQ11
	assign hit_own  = addr_hit(sh_q[7:1], own_q[7:1], 1'b0) && ctrl_q.ack; // RQ8 RQ9 RQ3
	assign wr_ctrl = WR_STB && (ADDR == `ADR_CTRL);

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= pair_s.scl;
			sda_prev_q <= pair_s.sda;
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// control, own address, transmit byte, interrupt enable
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			ctrl_q    <= '0;
			own_q     <= `OWN_RESET;
			tx_data_q <= 8'h00;
			irq_en_q  <= '0;
		end else if (WR_STB) begin
			case (ADDR)
				`ADR_CTRL: begin
					ctrl_q.en <= WR_DATA[`CTRL_EN];
					ctrl_q.ack <= WR_DATA[`CTRL_ACK];
					ctrl_q.px <= WR_DATA[`CTRL_PX];
				end
				`ADR_OWN:    own_q     <= WR_DATA;
				`ADR_TXDATA: tx_data_q <= WR_DATA;
				`ADR_IRQ_EN: irq_en_q  <= WR_DATA[`IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// serial flag: set on each new status, cleared by writing zero
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			si_q <= 1'b0;
		end else if (ev_q) begin
			si_q <= 1'b1; // RQ14
		end else if (wr_ctrl && !WR_DATA[`CTRL_SI]) begin
			si_q <= 1'b0;
		end
	end

	// sticky interrupt causes, set wins over clear
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			irq_sts_q <= '0;
		end else begin
			irq_sts_q <= (irq_sts_q & ~((WR_STB && ADDR == `ADR_IRQ_CLR) ? WR_DATA[`IRQ_W-1:0] : '0))
				| {drop_ev_q, hit_ev_q, ev_q};
		end
	end

	// level interrupt from enabled causes
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_sts_q & irq_en_q);
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			rd_q <= 8'h00;
		end else if (RD_STB) begin
			case (ADDR)
				`ADR_CTRL:    rd_q <= 8'h00 | (8'(ctrl_q.en) << `CTRL_EN) | (8'(si_q) << `CTRL_SI)
					| (8'(ctrl_q.ack) << `CTRL_ACK) | (8'(ctrl_q.px) << `CTRL_PX);
				`ADR_OWN:     rd_q <= own_q;
				`ADR_STATUS:  rd_q <= status_q;
				`ADR_TXDATA:  rd_q <= tx_data_q;
				`ADR_RXDATA:  rd_q <= rx_data_q;
				`ADR_IRQ_STS: rd_q <= 8'(irq_sts_q);
				`ADR_IRQ_EN:  rd_q <= 8'(irq_en_q);
				default:      rd_q <= 8'h00;
			endcase
		end else begin
			rd_q <= 8'h00;
		end
	end

	// ----------------------------------------
	// slave sequencer
	// ----------------------------------------
	// whole sequencer held idle while the interface is off
	always_ff @(posedge SYS_CLK) begin
		ev_q      <= 1'b0;
		hit_ev_q  <= 1'b0;
		drop_ev_q <= 1'b0;
		if (!RESETN || !ctrl_q.en) begin // RQ15
			state_q     <= i2c_ack_pkg::ST_IDLE;
			cnt_q       <= 4'h0;
			sh_q        <= 8'h00;
			sda_drv_q   <= 1'b0;
			addressed_q <= 1'b0;
			call_q      <= 1'b0;
			rw_q        <= 1'b0;
			acked_q     <= 1'b0;
			last_q      <= 1'b0;
			if (!RESETN) begin
				status_q  <= `STATUS_RESET;
				rx_data_q <= 8'h00;
			end
		end else if (start_c || stop_c) begin
			// first byte after any start is an address byte
			if (addressed_q) begin
				status_q <= `ST_STOP;
				ev_q     <= 1'b1;
			end
			state_q     <= start_c ? i2c_ack_pkg::ST_ADDR : i2c_ack_pkg::ST_IDLE; // RQ13
			cnt_q       <= 4'h0;
			sda_drv_q   <= 1'b0;
			addressed_q <= 1'b0;
		end else begin
			case (state_q)
				i2c_ack_pkg::ST_ADDR: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], pair_s.sda};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == `BITS_BYTE) begin
						// slave-only path: no master use of own address
						if (hit_own || hit_call) begin // RQ10
							sda_drv_q <= 1'b1; // RQ9
							call_q    <= hit_call;
							rw_q      <= sh_q[0];
							state_q   <= i2c_ack_pkg::ST_ACK_A;
						end else begin
							state_q <= i2c_ack_pkg::ST_IDLE; // RQ3
						end
					end
				end
				i2c_ack_pkg::ST_ACK_A: begin
					if (scl_fall) begin
						sda_drv_q   <= 1'b0;
						addressed_q <= 1'b1;
						ev_q        <= 1'b1;
						hit_ev_q    <= 1'b1;
						cnt_q       <= 4'h0;
						status_q    <= call_q ? `ST_CALL_W : (rw_q ? `ST_OWN_R : `ST_OWN_W);
						state_q     <= rw_q ? i2c_ack_pkg::ST_TX_LOAD : i2c_ack_pkg::ST_RX; // RQ16
					end
				end
				i2c_ack_pkg::ST_RX: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], pair_s.sda};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == `BITS_BYTE) begin
						rx_data_q <= sh_q;
						acked_q   <= ctrl_q.ack;
						sda_drv_q <= ctrl_q.ack; // RQ1 RQ2
						state_q   <= i2c_ack_pkg::ST_RX_ACK;
					end
				end
				i2c_ack_pkg::ST_RX_ACK: begin
					if (scl_fall) begin
						sda_drv_q <= 1'b0;
						ev_q      <= 1'b1;
						cnt_q     <= 4'h0;
						if (call_q) begin
							status_q <= acked_q ? `ST_CALL_ACK : `ST_CALL_NACK;
						end else begin
							status_q <= acked_q ? `ST_RX_ACK : `ST_RX_NACK;
						end
						if (acked_q) begin
							state_q <= i2c_ack_pkg::ST_RX;
						end else begin
							addressed_q <= 1'b0; // RQ4
							drop_ev_q   <= 1'b1;
							state_q     <= i2c_ack_pkg::ST_IDLE;
						end
					end
				end
				i2c_ack_pkg::ST_TX_LOAD: begin
					// wait until software has released the stretched clock
					if (!si_q && !ev_q) begin
						sh_q      <= tx_data_q;
						sda_drv_q <= ~tx_data_q[7];
						cnt_q     <= 4'h0;
						last_q    <= ~ctrl_q.ack; // RQ5
						state_q   <= i2c_ack_pkg::ST_TX;
					end
				end
				i2c_ack_pkg::ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == `LAST_TX_FALL) begin
							sda_drv_q <= 1'b0;
							state_q   <= i2c_ack_pkg::ST_TX_ACK;
						end else begin
							sh_q      <= {sh_q[6:0], 1'b0};
							sda_drv_q <= ~sh_q[6];
							cnt_q     <= cnt_q + 4'h1;
						end
					end
				end
				i2c_ack_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						acked_q <= ~pair_s.sda;
					end else if (scl_fall) begin
						ev_q <= 1'b1;
						if (acked_q && !last_q) begin
							status_q <= `ST_TX_ACK;
							state_q  <= i2c_ack_pkg::ST_TX_LOAD;
						end else begin
							// released SDA: master reads all ones afterwards
							status_q    <= acked_q ? `ST_TX_LAST : `ST_TX_NACK; // RQ5 RQ4
							addressed_q <= 1'b0;
							drop_ev_q   <= 1'b1;
							state_q     <= i2c_ack_pkg::ST_IDLE;
						end
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// clock stretch and pin drivers
	// ----------------------------------------
	// hold SCL low while the flag waits for software and the sequencer is not idle
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			scl_drv_q <= 1'b0;
		end else begin
			scl_drv_q <= ctrl_q.en && si_q && state_q != i2c_ack_pkg::ST_IDLE && !pair_s.scl; // RQ14
		end
	end

	// enables steered to the selected pair only
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			scl_a_oe_q <= 1'b0;
			sda_a_oe_q <= 1'b0;
			scl_b_oe_q <= 1'b0;
			sda_b_oe_q <= 1'b0;
		end else begin
			scl_a_oe_q <= scl_drv_q & ~ctrl_q.px; // RQ6 RQ7
			sda_a_oe_q <= sda_drv_q & ~ctrl_q.px;
			scl_b_oe_q <= scl_drv_q & ctrl_q.px;
			sda_b_oe_q <= sda_drv_q & ctrl_q.px;
		end
	end

	// open drain: driven level is always low
	assign SCL_A_OUT = 1'b0;
	assign SDA_A_OUT = 1'b0;
	assign SCL_B_OUT = 1'b0;
	assign SDA_B_OUT = 1'b0;
	assign SCL_A_OE  = scl_a_oe_q;
	assign SDA_A_OE  = sda_a_oe_q;
	assign SCL_B_OE  = scl_b_oe_q;
	assign SDA_B_OE  = sda_b_oe_q;
	assign RD_DATA   = rd_q;
	assign IRQ       = irq_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	ack_drive_a: assert property ( // RQ1
		state_q == i2c_ack_pkg::ST_ACK_A |-> sda_drv_q ##1 (sda_drv_q || !addressed_q || ev_q))
		else $error("address ack not driven");

	nack_release_a: assert property ( // RQ2
		(state_q == i2c_ack_pkg::ST_RX_ACK && !acked_q) |-> !sda_drv_q)
		else $error("sda driven during nack");

	ignore_quiet_a: assert property ( // RQ3
		(state_q == i2c_ack_pkg::ST_ADDR ##1 state_q == i2c_ack_pkg::ST_IDLE) |-> !ev_q && !hit_ev_q)
		else $error("flag raised for ignored address");

	drop_nack_a: assert property ( // RQ4
		(state_q == i2c_ack_pkg::ST_RX_ACK && !acked_q && scl_fall && !start_c && !stop_c && ctrl_q.en)
		|=> !addressed_q && state_q == i2c_ack_pkg::ST_IDLE && status_q != `ST_RX_ACK)
		else $error("slave kept address after nack");

	last_byte_a: assert property ( // RQ5
		(state_q == i2c_ack_pkg::ST_TX_ACK && acked_q && last_q && scl_fall && !start_c && !stop_c && ctrl_q.en)
		|=> status_q == `ST_TX_LAST && !addressed_q ##1 si_q)
		else $error("last byte did not report c8");

	pin_route_a: assert property ( // RQ6
		(SCL_B_OE || SDA_B_OE) |-> $past(ctrl_q.px) && !SCL_A_OE && !SDA_A_OE)
		else $error("drive on unselected pair");

	addr_match_a: assert property ( // RQ9
		$rose(state_q == i2c_ack_pkg::ST_ACK_A) |-> $past(ctrl_q.ack)
		&& (call_q || (sh_q[7:1] == own_q[7:1] && sh_q[7:1] != `CALL_ADDR)))
		else $error("ack given without address match");

	call_gate_a: assert property ( // RQ11
		($rose(state_q == i2c_ack_pkg::ST_ACK_A) && call_q) |-> $past(own_q[`OWN_CALL] && ctrl_q.ack))
		else $error("general call taken while disabled");

	flag_stretch_a: assert property ( // RQ14
		ev_q |=> si_q ##1 (!si_q || state_q == i2c_ack_pkg::ST_IDLE || pair_s.scl || scl_drv_q))
		else $error("flag or clock stretch missing");

	disabled_a: assert property ( // RQ15
		!ctrl_q.en |=> state_q == i2c_ack_pkg::ST_IDLE && !sda_drv_q ##1 !SDA_A_OE && !SDA_B_OE)
		else $error("bus active while disabled");

	direction_a: assert property ( // RQ16
		(state_q == i2c_ack_pkg::ST_TX_LOAD || state_q == i2c_ack_pkg::ST_TX) |-> rw_q && !call_q)
		else $error("transmit without read address");

	own_write_c: cover property (state_q == i2c_ack_pkg::ST_ACK_A && !rw_q && !call_q ##[1:600] status_q == `ST_RX_ACK);
	own_read_c:  cover property (status_q == `ST_OWN_R ##[1:900] status_q == `ST_TX_ACK);
	last_c:      cover property (status_q == `ST_TX_LAST);
	call_c:      cover property (status_q == `ST_CALL_W);

endmodule

// File: i2c_master_model.sv
`timescale 1ns/10ps

// behavioural bus master on one scl/sda pair; released lines float high
module i2c_master_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      m_scl,
	output logic      m_sda
);
	localparam real QTR = 31.25;

	// ----------------------------------------
	// idle bus
	// ----------------------------------------
	initial begin
		m_scl = 1'b1;
		m_sda = 1'b1;
	end

	// ----------------------------------------
	// bit and byte level
	// ----------------------------------------
	// one clock pulse; waits while the slave stretches scl low
	task automatic pulse(input logic d, output logic s);
		#QTR m_sda = d;
		#QTR m_scl = 1'b1;
		for (int i = 0; i < 20000 && scl !== 1'b1; i++)
			#4;
		#QTR s = sda;
		#QTR m_scl = 1'b0;
	endtask

	// start from an idle bus
	task automatic start();
		#QTR m_sda = 1'b0;
		#QTR m_scl = 1'b0;
	endtask

	// stop after a byte, scl low on entry
	task automatic stop();
		#QTR m_sda = 1'b0;
		#QTR m_scl = 1'b1;
		#QTR m_sda = 1'b1;
		#QTR;
	endtask

	// msb first, ack seen as sda low on the ninth pulse
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			pulse(b[i], s);
		pulse(1'b1, s);
		ack = (s === 1'b0);
	endtask

	// read eight bits, then ack (low) or nack (released)
	task automatic rd_byte(input logic a, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			pulse(1'b1, b[i]);
		pulse(~a, s);
	endtask
endmodule

// File: test_i2c_slave_addressing_ack.sv
`timescale 1ns/10ps
`include "i2c_ack_defs.svh"

module test_i2c_slave_addressing_ack;
	logic       clk, rst_n, wr_stb, rd_stb, irq, sel, ack, m_scl, m_sda;
	logic [7:0] addr, wr_data, rd_data, rb, ctrl_v;
	logic       sca_oe, sda_oe, scb_oe, sdb_oe, sca_o, sda_o, scb_o, sdb_o;
	wire        scl_a, sda_a, scl_b, sda_b;
	int         fail_count, n_checks, stray;

	// ----------------------------------------
	// wired-and pins with pull-ups
	// ----------------------------------------
	assign scl_a = (sel | m_scl) & (sca_oe ? sca_o : 1'b1);
	assign sda_a = (sel | m_sda) & (sda_oe ? sda_o : 1'b1);
	assign scl_b = (~sel | m_scl) & (scb_oe ? scb_o : 1'b1);
	assign sda_b = (~sel | m_sda) & (sdb_oe ? sdb_o : 1'b1);

	i2c_slave_addressing_ack dut (.SYS_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WR_DATA(wr_data),
		.WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .IRQ(irq),
		.SCL_A_IN(scl_a), .SCL_A_OUT(sca_o), .SCL_A_OE(sca_oe),
		.SDA_A_IN(sda_a), .SDA_A_OUT(sda_o), .SDA_A_OE(sda_oe),
		.SCL_B_IN(scl_b), .SCL_B_OUT(scb_o), .SCL_B_OE(scb_oe),
		.SDA_B_IN(sda_b), .SDA_B_OUT(sdb_o), .SDA_B_OE(sdb_oe));

	i2c_master_model mdl (.scl(sel ? scl_b : scl_a), .sda(sel ? sda_b : sda_a), .m_scl(m_scl), .m_sda(m_sda));

	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// the pair not selected must never be driven
	always @(posedge clk) begin
		if (sel ? (sca_oe | sda_oe) : (scb_oe | sdb_oe))
			stray++;
	end

	// ----------------------------------------
	// bus tasks and checks
	// ----------------------------------------
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 chk8(what, exp, rd_data);
	endtask

	// flag, stretch and status after an event, then release the bus
	task automatic expect_ev(input logic [7:0] st, input logic strch);
		for (int i = 0; i < 100 && irq !== 1'b1; i++)
			@(posedge clk);
		chk8("irq", 8'h01, {7'h0, irq});
		repeat (4) @(posedge clk);
		if (strch)
			chk8("stretch", 8'h01, {7'h0, sel ? scb_oe : sca_oe});
		rd(`ADR_STATUS, st, "status");
		rd(`ADR_CTRL, ctrl_v | 8'h08, "ctrl");
		wr(`ADR_CTRL, ctrl_v);
		wr(`ADR_IRQ_CLR, 8'hff);
	endtask

	task automatic expect_none();
		repeat (40) @(posedge clk);
		chk8("irq", 8'h00, {7'h0, irq});
		rd(`ADR_IRQ_STS, 8'h00, "irq status");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd(`ADR_OWN, `OWN_RESET, "own reset");
		rd(`ADR_STATUS, `STATUS_RESET, "status reset");
		rd(`ADR_CTRL, 8'h00, "ctrl reset");
		rd(8'he0, 8'h00, "unmapped");
		wr(8'he0, 8'h55);
		wr(`ADR_OWN, 8'ha4);
		rd(`ADR_OWN, 8'ha4, "own rw");
		wr(`ADR_IRQ_EN, 8'h01);
	endtask

	task automatic t_write();
		ctrl_v = 8'h44;
		wr(`ADR_CTRL, ctrl_v);
		mdl.start();
		mdl.wr_byte(8'ha4, ack);
		chk8("addr ack", 8'h01, {7'h0, ack});
		repeat (30) @(posedge clk);
		rd(`ADR_IRQ_STS, 8'h03, "irq status");
		wr(`ADR_IRQ_EN, 8'h00);
		repeat (2) @(posedge clk);
		chk8("irq masked", 8'h00, {7'h0, irq});
		wr(`ADR_IRQ_EN, 8'h01);
		expect_ev(`ST_OWN_W, 1'b1);
		mdl.wr_byte(8'h3c, ack);
		chk8("data ack", 8'h01, {7'h0, ack});
		expect_ev(`ST_RX_ACK, 1'b1);
		rd(`ADR_RXDATA, 8'h3c, "rx byte");
		ctrl_v = 8'h40;
		wr(`ADR_CTRL, ctrl_v);
		mdl.wr_byte(8'hc3, ack);
		chk8("data nack", 8'h00, {7'h0, ack});
		expect_ev(`ST_RX_NACK, 1'b0);
		mdl.wr_byte(8'h99, ack);
		chk8("ignored ack", 8'h00, {7'h0, ack});
		expect_none();
		mdl.stop();
	endtask

	task automatic t_refuse();
		logic [7:0] rc [3] = '{8'h40, 8'h04, 8'h44};
		logic [7:0] ra [3] = '{8'ha4, 8'ha4, 8'ha6};
		for (int i = 0; i < 3; i++) begin
			ctrl_v = rc[i];
			wr(`ADR_CTRL, ctrl_v);
			mdl.start();
			mdl.wr_byte(ra[i], ack);
			chk8("refused ack", 8'h00, {7'h0, ack});
			expect_none();
			mdl.stop();
		end
	endtask

	task automatic t_call();
		for (int i = 0; i < 4; i++) begin
			ctrl_v = {5'b01000, i[1], 2'b00};
			wr(`ADR_CTRL, ctrl_v);
			wr(`ADR_OWN, {7'h52, i[0]});
			mdl.start();
			mdl.wr_byte({`CALL_ADDR, 1'b0}, ack);
			chk8("call ack", {7'h0, i[0] & i[1]}, {7'h0, ack});
			if (i == 3) begin
				expect_ev(`ST_CALL_W, 1'b1);
				mdl.wr_byte(8'h12, ack);
				chk8("call data ack", 8'h01, {7'h0, ack});
				expect_ev(`ST_CALL_ACK, 1'b1);
			end else
				expect_none();
			mdl.stop();
			if (i == 3)
				expect_ev(`ST_STOP, 1'b0);
		end
	endtask

	task automatic t_read();
		ctrl_v = 8'h44;
		wr(`ADR_CTRL, ctrl_v);
		wr(`ADR_OWN, 8'ha4);
		wr(`ADR_TXDATA, 8'h5a);
		mdl.start();
		mdl.wr_byte(8'ha5, ack);
		chk8("read addr ack", 8'h01, {7'h0, ack});
		expect_ev(`ST_OWN_R, 1'b1);
		mdl.rd_byte(1'b1, rb);
		chk8("tx byte", 8'h5a, rb);
		wr(`ADR_TXDATA, 8'h81);
		ctrl_v = 8'h40;
		wr(`ADR_CTRL, 8'h48);
		expect_ev(`ST_TX_ACK, 1'b1);
		mdl.rd_byte(1'b1, rb);
		chk8("last byte", 8'h81, rb);
		expect_ev(`ST_TX_LAST, 1'b0);
		mdl.rd_byte(1'b0, rb);
		chk8("after last", 8'hff, rb);
		expect_none();
		mdl.stop();
	endtask

	task automatic t_pins();
		ctrl_v = 8'h45;
		wr(`ADR_CTRL, ctrl_v);
		sel = 1'b1;
		mdl.start();
		mdl.wr_byte(8'ha4, ack);
		chk8("pair b ack", 8'h01, {7'h0, ack});
		expect_ev(`ST_OWN_W, 1'b1);
		mdl.wr_byte(8'h77, ack);
		chk8("pair b data", 8'h01, {7'h0, ack});
		expect_ev(`ST_RX_ACK, 1'b1);
		mdl.stop();
		expect_ev(`ST_STOP, 1'b0);
		ctrl_v = 8'h44;
		wr(`ADR_CTRL, ctrl_v);
		sel = 1'b0;
		chk8("stray drive", 8'h00, stray[7:0]);
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog against a hung bus
	initial begin
		#200us;
		fail_count++;
		end_sim();
	end

	// main sequence
	initial begin
		{addr, wr_data, wr_stb, rd_stb, rst_n, sel} = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_write();
		t_refuse();
		t_call();
		t_read();
		t_pins();
		end_sim();
	end
endmodule
